/* ligc_top.sv */
`timescale 1ns/1ns
// Function
// RULE1: Bit 7 selects single or dual rail
// RULE2: Software also sets framer rail setting
// RULE3: Bit 6 sends all ones on loss
// RULE4: Bit 5 picks receive rail update edge
// RULE5: Bit 4 picks transmit rail sample edge
// RULE6: Bit 3 inverts transmit and receive data
// RULE7: Bit 1 low blocks the interrupt
// RULE8: Interrupt needs gate, source enable, status
// RULE9: Reset starts after bit held 10us
// RULE10: Software reset spares register bits
// RULE11: Bit 2 reads zero, ignores writes
module ligc_top #(
  parameter int HOLD_CYC = ligc_pkg::SWRST_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [11:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic receive_signal_loss,
  input wire logic src_status,
  input wire logic src_enable,
  input wire logic bypass_mode,
  input wire logic tx_data,
  input wire logic rx_data,
  output logic single_rail_select,
  output logic rx_clk_falling,
  output logic tx_clk_rising,
  output logic tx_line_data,
  output logic rx_out_data,
  output logic cpu_int,
  output logic internal_reset
);
  import ligc_pkg::*;

  logic [7:0] gc0_q;
  logic [31:0] hold_cnt_q;
  logic loss_s;
  logic sel;
  logic hold_done;

  ligc_sync #(.W(1)) u_loss_sync (
    .mclk(mclk),
    .rst(rst),
    .d(receive_signal_loss),
    .q(loss_s)
  );

  // Single register, so a full-width compare is the whole decode
  function automatic logic gc0_hit(input logic [11:0] addr);
    return addr == GC0_ADDR;
  endfunction : gc0_hit

  assign sel = gc0_hit(cpu_addr);

  // Only hardware reset clears the register; the software reset leaves it alone
  always_ff @(posedge mclk) begin
    if (rst) begin
      gc0_q <= GC0_RESET;
    end else if (cpu_wr && sel) begin
      gc0_q <= cpu_wdata & GC0_WMASK; // RULE10 RULE11
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd && sel) begin
      cpu_rdata <= gc0_q & GC0_WMASK; // RULE11
    end else begin
      cpu_rdata <= 8'h00;
    end
  end

  // Counts cycles with the reset bit held; a drop restarts the wait
  always_ff @(posedge mclk) begin
    if (rst || !gc0_q[BIT_SWRST]) begin
      hold_cnt_q <= '0;
    end else if (!hold_done) begin
      hold_cnt_q <= hold_cnt_q + 32'h1; // RULE9
    end
  end

  assign hold_done = (hold_cnt_q >= 32'(HOLD_CYC));

  always_ff @(posedge mclk) begin
    if (rst) begin
      internal_reset <= 1'b0;
    end else begin
      internal_reset <= hold_done && gc0_q[BIT_SWRST]; // RULE9 RULE10
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      single_rail_select <= 1'b0;
      rx_clk_falling <= 1'b0;
      tx_clk_rising <= 1'b0;
    end else begin
      single_rail_select <= gc0_q[BIT_SINGLE_RAIL]; // RULE1
      rx_clk_falling <= bypass_mode & gc0_q[BIT_RXEDGE]; // RULE4
      tx_clk_rising <= bypass_mode & gc0_q[BIT_TXEDGE]; // RULE5
    end
  end

  // Data path: polarity applied, all ones override on transmit during signal loss
  always_ff @(posedge mclk) begin
    if (rst || internal_reset) begin
      tx_line_data <= 1'b0;
      rx_out_data <= 1'b0;
    end else begin
      if (gc0_q[BIT_ALL_ONES] && loss_s) begin
        tx_line_data <= 1'b1; // RULE3
      end else begin
        tx_line_data <= tx_data ^ gc0_q[BIT_POL]; // RULE6
      end
      rx_out_data <= rx_data ^ gc0_q[BIT_POL]; // RULE6
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || internal_reset) begin
      cpu_int <= 1'b0;
    end else begin
      cpu_int <= gc0_q[BIT_GATE] && src_enable && src_status; // RULE7 RULE8
    end
  end

  a_int_gate_off: assert property (@(posedge mclk) disable iff (rst) // RULE7
    !gc0_q[BIT_GATE] |=> !cpu_int) else $error("interrupt with gate off");

  a_int_cause: assert property (@(posedge mclk) disable iff (rst) // RULE8
    $rose(cpu_int) |-> $past(src_enable && src_status && gc0_q[BIT_GATE]))
    else $error("interrupt without cause");

  a_all_ones_loss: assert property (@(posedge mclk) disable iff (rst) // RULE3
    (gc0_q[BIT_ALL_ONES] && loss_s && !internal_reset) |=> tx_line_data)
    else $error("all ones not sent");

  a_rail_select: assert property (@(posedge mclk) disable iff (rst) // RULE1
    ##1 single_rail_select == $past(gc0_q[BIT_SINGLE_RAIL])) else $error("rail select wrong");

  a_bit2_zero: assert property (@(posedge mclk) disable iff (rst) // RULE11
    !cpu_rdata[2] && !gc0_q[2]) else $error("bit 2 not zero");

  a_rst_early: assert property (@(posedge mclk) disable iff (rst) // RULE9
    $rose(internal_reset) |-> $past(hold_cnt_q) >= 32'(HOLD_CYC))
    else $error("software reset too early");

  a_reg_kept: assert property (@(posedge mclk) disable iff (rst) // RULE10
    (internal_reset && !cpu_wr) |=> $stable(gc0_q)) else $error("register lost");

  a_rx_edge: assert property (@(posedge mclk) disable iff (rst) // RULE4
    (!bypass_mode) |=> !rx_clk_falling) else $error("edge outside bypass");

  a_tx_edge: assert property (@(posedge mclk) disable iff (rst) // RULE5
    (bypass_mode && gc0_q[BIT_TXEDGE]) |=> tx_clk_rising) else $error("tx edge wrong");

  a_rx_pol: assert property (@(posedge mclk) disable iff (rst) // RULE6
    !internal_reset |=> rx_out_data == ($past(rx_data) ^ $past(gc0_q[BIT_POL])))
    else $error("rx polarity wrong");

  // Register path: writes land masked, reads return the stored byte for one cycle
  a_reg_write: assert property (@(posedge mclk) disable iff (rst) // RULE11
    (cpu_wr && sel) |=> gc0_q == ($past(cpu_wdata) & GC0_WMASK))
    else $error("register write lost");

  a_rdata_value: assert property (@(posedge mclk) disable iff (rst) // RULE11
    (cpu_rd && sel) |=> cpu_rdata == $past(gc0_q))
    else $error("read data wrong");

  a_rdata_idle: assert property (@(posedge mclk) disable iff (rst) // RULE11
    !(cpu_rd && sel) |=> cpu_rdata == 8'h00)
    else $error("read data not idle");

  a_rail_low: assert property (@(posedge mclk) disable iff (rst) // RULE1
    !gc0_q[BIT_SINGLE_RAIL] |=> !single_rail_select)
    else $error("single rail without bit");

  a_rx_edge_on: assert property (@(posedge mclk) disable iff (rst) // RULE4
    (bypass_mode && gc0_q[BIT_RXEDGE]) |=> rx_clk_falling)
    else $error("rx edge not selected");

  a_tx_edge_off: assert property (@(posedge mclk) disable iff (rst) // RULE5
    !gc0_q[BIT_TXEDGE] |=> !tx_clk_rising)
    else $error("tx edge without bit");

  a_tx_pol: assert property (@(posedge mclk) disable iff (rst) // RULE6
    (!internal_reset && !(gc0_q[BIT_ALL_ONES] && loss_s)) |=>
    tx_line_data == ($past(tx_data) ^ $past(gc0_q[BIT_POL])))
    else $error("tx polarity wrong");

  a_all_ones_off: assert property (@(posedge mclk) disable iff (rst) // RULE3
    (!gc0_q[BIT_ALL_ONES] && !internal_reset && !tx_data && !gc0_q[BIT_POL]) |=> !tx_line_data)
    else $error("all ones while disabled");

  // Software reset: needs the stored bit, stays while it is held, clears the data and interrupt outputs
  a_rst_needs_bit: assert property (@(posedge mclk) disable iff (rst) // RULE9
    !gc0_q[BIT_SWRST] |=> !internal_reset)
    else $error("software reset without bit");

  a_rst_stays: assert property (@(posedge mclk) disable iff (rst) // RULE9
    (internal_reset && gc0_q[BIT_SWRST]) |=> internal_reset)
    else $error("software reset dropped early");

  a_hold_bound: assert property (@(posedge mclk) disable iff (rst) // RULE9
    hold_cnt_q <= 32'(HOLD_CYC))
    else $error("hold counter ran past limit");

  a_rst_clears_out: assert property (@(posedge mclk) disable iff (rst) // RULE10
    internal_reset |=> (!cpu_int && !rx_out_data && !tx_line_data))
    else $error("outputs not cleared by reset");

  // Interrupt path: the source enable is needed, and outside software reset gate, source enable and status together suffice
  a_int_needs_src: assert property (@(posedge mclk) disable iff (rst) // RULE8
    !src_enable |=> !cpu_int)
    else $error("interrupt without source enable");

  a_int_fires: assert property (@(posedge mclk) disable iff (rst) // RULE8
    (gc0_q[BIT_GATE] && src_enable && src_status && !internal_reset) |=> cpu_int)
    else $error("interrupt not raised");
endmodule : ligc_top

/* ligc_pkg.sv */
package ligc_pkg;
  localparam logic [11:0] GC0_ADDR = 12'hfe0;
  localparam logic [7:0] GC0_RESET = 8'h00;
  localparam logic [7:0] GC0_WMASK = 8'hfb;
  localparam int BIT_SINGLE_RAIL = 7;
  localparam int BIT_ALL_ONES = 6;
  localparam int BIT_RXEDGE = 5;
  localparam int BIT_TXEDGE = 4;
  localparam int BIT_POL = 3;
  localparam int BIT_GATE = 1;
  localparam int BIT_SWRST = 0;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SWRST_HOLD_NS = 10000;
  // More than the hold time: floor plus one cycle
  localparam int SWRST_HOLD_CYC = SWRST_HOLD_NS / CLK_PERIOD_NS + 1;
  localparam int SYNC_STAGES = 3;
endpackage : ligc_pkg

/* ligc_sync.sv */
`timescale 1ns/1ns
// Three-stage synchroniser; change accepted when stages two and three agree
module ligc_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import ligc_pkg::*;
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : ligc_sync

/* tb_top.sv */
`timescale 1ns/1ns
`define CMP(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  import ligc_pkg::*;
  localparam int HOLD = 4;
  logic mclk = 0;
  logic rst = 1;
  logic rst_q = 1;
  logic [11:0] cpu_addr = 0;
  logic cpu_wr = 0, cpu_rd = 0, receive_signal_loss = 0, src_status = 0, src_enable = 0;
  logic bypass_mode = 0, tx_data = 0, rx_data = 0;
  logic [7:0] cpu_wdata = 0, cpu_rdata, reg_m, exp_rd;
  logic srs, rcf, tcr, tld, rod, cint, irst;
  logic [5:0] e;
  logic [31:0] lf = 32'h09d03871;
  int checks = 0, n_fail = 0, hc = 0, lc = 0, i;
  logic loss_q = 0, exp_irst = 0, blk;
  ligc_top #(.HOLD_CYC(HOLD)) i_ligc_top (.mclk(mclk), .rst(rst), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .receive_signal_loss(receive_signal_loss), .src_status(src_status),
    .src_enable(src_enable), .bypass_mode(bypass_mode), .tx_data(tx_data),
    .rx_data(rx_data), .single_rail_select(srs), .rx_clk_falling(rcf),
    .tx_clk_rising(tcr), .tx_line_data(tld), .rx_out_data(rod), .cpu_int(cint),
    .internal_reset(irst));
  initial begin
    forever #4 mclk = ~mclk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  always @(posedge mclk) begin
    rst_q <= rst;
    loss_q <= receive_signal_loss;
    lc <= (receive_signal_loss != loss_q) ? 0 : lc + 1;
    // Data and interrupt follow the software reset as it stood at this edge
    blk = rst || exp_irst;
    if (rst) begin
      reg_m <= GC0_RESET;
      exp_rd <= 8'h00;
      hc <= 0;
      exp_irst <= 1'b0;
    end else begin
      if (cpu_wr && cpu_addr == GC0_ADDR) reg_m <= cpu_wdata & GC0_WMASK;
      exp_rd <= (cpu_rd && cpu_addr == GC0_ADDR) ? reg_m : 8'h00;
      hc <= reg_m[BIT_SWRST] ? hc + 1 : 0;
      exp_irst <= reg_m[BIT_SWRST] && hc >= HOLD;
    end
    e[0] <= reg_m[BIT_SINGLE_RAIL];
    e[1] <= bypass_mode & reg_m[BIT_RXEDGE];
    e[2] <= bypass_mode & reg_m[BIT_TXEDGE];
    e[3] <= !blk && ((reg_m[BIT_ALL_ONES] & receive_signal_loss) | (tx_data ^ reg_m[BIT_POL]));
    e[4] <= !blk && (rx_data ^ reg_m[BIT_POL]);
    e[5] <= !blk && (reg_m[BIT_GATE] & src_enable & src_status);
  end
  always @(negedge mclk) begin
    if (!rst && !rst_q) begin
      `CMP(cpu_rdata, exp_rd)
      `CMP(srs, e[0])
      `CMP(rcf, e[1])
      `CMP(tcr, e[2])
      `CMP(irst, exp_irst)
      if (lc > 8) `CMP(tld, e[3])
      `CMP(rod, e[4])
      `CMP(cint, e[5])
    end
  end
  // One assignment per signal per cycle; directed cycles hold the loss input low
  task automatic drive(input bit rnd, input logic w, input logic r, input logic [7:0] d);
    @(posedge mclk);
    #1;
    lf = nxt(lf);
    {tx_data, rx_data, src_status, src_enable, bypass_mode} = lf[4:0];
    cpu_wr = rnd ? lf[5] & lf[6] : w;
    cpu_rd = rnd ? lf[7] & ~(lf[5] & lf[6]) : r;
    cpu_addr = (lf[8] || !rnd) ? GC0_ADDR : lf[20:9];
    cpu_wdata = rnd ? lf[31:24] & 8'hfe : d;
    receive_signal_loss = rnd ? receive_signal_loss ^ (lf[23:20] == 4'h0) : 1'b0;
  endtask : drive
  task automatic step(input bit rnd);
    drive(rnd, 1'b0, 1'b0, 8'h00);
  endtask : step
  task automatic op(input logic w, input logic r, input logic [7:0] d);
    drive(1'b0, w, r, d);
  endtask : op
  task close_out;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (16) @(posedge mclk);
    #1 rst = 0;
    repeat (3000) step(1);
    op(1, 0, 8'hff);
    for (i = 0; i < 40 && irst !== 1'b1; i++) step(0);
    if (irst !== 1'b1) begin
      n_fail++;
    end else begin
      repeat (6) step(0);
      op(0, 1, 8'h00);
      op(1, 0, 8'h00);
      op(0, 1, 8'h00);
      repeat (6) step(0);
      op(1, 0, 8'hfe);
      step(0);
      rst = 1;
      repeat (3) step(0);
      rst = 0;
      repeat (3) step(0);
      op(0, 1, 8'h00);
      repeat (500) step(1);
    end
    step(0);
    close_out();
  end
endmodule : tb_top
